// ### hdl/pll_lock_detect.sv
// Digital lock detector with counter reset and path delay control
`timescale 1ns/10ps
module pll_lock_detect
    import lock_detect_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // Register port
    input wire reg_req_t REG_REQ,
    output logic [DATA_W-1:0] REG_RDATA,
    // Comparator cycle results
    input wire cmp_sample_t CMP_SAMPLE,
    // Align pin request, one cycle pulse
    input wire logic ALIGN_REQ,
    // Loop controls and status
    output loop_ctrl_t LOOP_CTRL,
    output logic LOCK_STATUS_PIN,
    output logic IRQ
);

    // ==========================================================
    // Register decode
    logic [7:0] idx;
    logic [REG_W-1:0] lock_cfg_q;
    logic [REG_W-1:0] cnt_delay_q;
    logic [REG_W-1:0] abl_cfg_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic lock_q;
    logic [7:0] run_q;

    assign idx = REG_REQ.addr[ADDR_W-1:ADDR_LSB];

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            lock_cfg_q <= RST_LOCK_CFG;
            cnt_delay_q <= RST_CNT_DELAY;
            abl_cfg_q <= RST_ABL_CFG;
            irq_en_q <= '0;
        end else if (REG_REQ.wr) begin
            unique case (idx)
                IDX_LOCK_CFG: begin
                    lock_cfg_q <= REG_REQ.wdata[REG_W-1:0];
                end
                IDX_CNT_DELAY: begin
                    cnt_delay_q <= REG_REQ.wdata[REG_W-1:0];
                end
                IDX_ABL_CFG: begin
                    abl_cfg_q <= REG_REQ.wdata[REG_W-1:0];
                end
                IDX_IRQ_EN: begin
                    irq_en_q <= REG_REQ.wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            REG_RDATA <= '0;
        end else if (REG_REQ.rd) begin
            unique case (idx)
                IDX_LOCK_CFG: REG_RDATA <= {24'h000000, lock_cfg_q};
                IDX_CNT_DELAY: REG_RDATA <= {24'h000000, cnt_delay_q};
                IDX_ABL_CFG: REG_RDATA <= {24'h000000, abl_cfg_q};
                IDX_STATUS: REG_RDATA <= {24'h000000, run_q[6:0], lock_q};
                IDX_IRQ_STAT: REG_RDATA <= {30'h00000000, irq_stat_q};
                IDX_IRQ_EN: REG_RDATA <= {30'h00000000, irq_en_q};
                default: REG_RDATA <= '0;
            endcase
        end else begin
            REG_RDATA <= '0;
        end
    end

    // ==========================================================
    // Lock qualification
    logic [7:0] run_target;
    logic in_win;
    logic det_disabled;

    always_comb begin
        unique case (lock_cfg_q[F_CNT_SEL_LO +: 2])
            2'b00: run_target = RUN_5;
            2'b01: run_target = RUN_16;
            2'b10: run_target = RUN_64;
            2'b11: run_target = RUN_255;
        endcase
    end

    assign in_win = lock_cfg_q[F_WIN_SEL] ? CMP_SAMPLE.in_low_win : CMP_SAMPLE.in_high_win;
    assign det_disabled = lock_cfg_q[F_DET_DIS];

    always_ff @(posedge CORE_CLK) begin
        if (RESET || det_disabled) begin
            run_q <= '0;
        end else if (CMP_SAMPLE.valid && !lock_q) begin
            if (!in_win) begin
                run_q <= '0;
            end else if (run_q != run_target) begin
                run_q <= run_q + 8'h01;
            end
        end else if (lock_q) begin
            run_q <= '0;
        end
    end

    // Disabled detector reports unlocked, so no stale lock survives
    always_ff @(posedge CORE_CLK) begin
        if (RESET || det_disabled) begin
            lock_q <= 1'b0;
        end else if (CMP_SAMPLE.valid) begin
            if (!lock_q) begin
                if (in_win && (run_q + 8'h01 == run_target)) begin
                    lock_q <= 1'b1;
                end
            end else if (CMP_SAMPLE.beyond_loss) begin
                lock_q <= 1'b0;
            end
        end
    end

    assign LOCK_STATUS_PIN = lock_q;

    // ==========================================================
    // Interrupts
    logic lock_prev_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            lock_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= lock_q;
        end
    end

    assign irq_evt[IRQ_LOCK] = lock_q && !lock_prev_q;
    assign irq_evt[IRQ_UNLOCK] = !lock_q && lock_prev_q;
    assign irq_clr = (REG_REQ.wr && idx == IDX_IRQ_CLR) ? REG_REQ.wdata[IRQ_W-1:0] : '0;

    // Set wins over a simultaneous clear
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
        end
    end

    assign IRQ = |(irq_stat_q & irq_en_q);

    // ==========================================================
    // Counter reset and path controls
    sync_mode_t sync_mode;
    assign sync_mode = sync_mode_t'(cnt_delay_q[F_SYNC_LO +: 2]);

    // Async and sync counter resets are both one-cycle pulses registered from ALIGN_REQ
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            LOOP_CTRL <= '0;
        end else begin
            LOOP_CTRL.cnt_rst_async <= ALIGN_REQ && (sync_mode == SYNC_ASYNC);
            LOOP_CTRL.cnt_rst_sync <= ALIGN_REQ && (sync_mode == SYNC_SYNC);
            LOOP_CTRL.ref_delay <= cnt_delay_q[F_RDLY_LO +: 3];
            LOOP_CTRL.fb_delay <= cnt_delay_q[F_NDLY_LO +: 3];
            LOOP_CTRL.abl_code <= abl_cfg_q[F_ABL_LO +: 2];
            unique case (abl_cfg_q[F_ABL_LO +: 2])
                2'b01: LOOP_CTRL.abl_width_ps <= ABL_1P3_PS;
                2'b10: LOOP_CTRL.abl_width_ps <= ABL_6P0_PS;
                default: LOOP_CTRL.abl_width_ps <= ABL_2P9_PS;
            endcase
        end
    end

endmodule // pll_lock_detect

// ### hdl/lock_detect_pkg.sv
// Shared constants, register map and carrier types of the lock detector
package lock_detect_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_LOCK_CFG = 8'h18;
    localparam logic [7:0] IDX_CNT_DELAY = 8'h19;
    localparam logic [7:0] IDX_ABL_CFG = 8'h1A;
    localparam logic [7:0] IDX_STATUS = 8'h1B;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h1C;
    localparam logic [7:0] IDX_IRQ_EN = 8'h1D;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h1E;
    localparam int ADDR_W = 10;
    localparam int ADDR_LSB = 2;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // Field positions
    localparam int F_CNT_SEL_LO = 5;
    localparam int F_WIN_SEL = 4;
    localparam int F_DET_DIS = 3;
    localparam int F_SYNC_LO = 6;
    localparam int F_RDLY_LO = 3;
    localparam int F_NDLY_LO = 0;
    localparam int F_ABL_LO = 0;
    // Reset values
    localparam logic [7:0] RST_LOCK_CFG = 8'h00;
    localparam logic [7:0] RST_CNT_DELAY = 8'h00;
    localparam logic [7:0] RST_ABL_CFG = 8'h00;
    // Lock run lengths
    localparam logic [7:0] RUN_5 = 8'h05;
    localparam logic [7:0] RUN_16 = 8'h10;
    localparam logic [7:0] RUN_64 = 8'h40;
    localparam logic [7:0] RUN_255 = 8'hFF;
    // Antibacklash widths in picoseconds
    localparam logic [12:0] ABL_2P9_PS = 13'h0B54;
    localparam logic [12:0] ABL_1P3_PS = 13'h0514;
    localparam logic [12:0] ABL_6P0_PS = 13'h1770;
    // Interrupt bits
    localparam int IRQ_LOCK = 0;
    localparam int IRQ_UNLOCK = 1;
    localparam int IRQ_W = 2;

    typedef enum logic [1:0] {
        SYNC_NONE = 2'b00,
        SYNC_ASYNC = 2'b01,
        SYNC_SYNC = 2'b10,
        SYNC_NONE2 = 2'b11
    } sync_mode_t;

    // One comparator cycle as reported by the timing front end
    typedef struct packed {
        logic valid;
        logic in_high_win;
        logic in_low_win;
        logic beyond_loss;
    } cmp_sample_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic cnt_rst_async;
        logic cnt_rst_sync;
        logic [2:0] ref_delay;
        logic [2:0] fb_delay;
        logic [1:0] abl_code;
        logic [12:0] abl_width_ps;
    } loop_ctrl_t;
endpackage

// ### verification/pll_lock_detect_checker.sv
// Port assertions for the lock detector
`timescale 1ns/10ps
module pll_lock_detect_checker
    import lock_detect_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire reg_req_t REG_REQ,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire cmp_sample_t CMP_SAMPLE,
    input wire logic ALIGN_REQ,
    input wire loop_ctrl_t LOOP_CTRL,
    input wire logic LOCK_STATUS_PIN,
    input wire logic IRQ
);
    // ==========
    // Properties
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    logic miss;
    logic [12:0] abl_exp;
    assign miss = CMP_SAMPLE.valid && !CMP_SAMPLE.in_high_win && !CMP_SAMPLE.in_low_win;
    assign abl_exp = (LOOP_CTRL.abl_code == 2'h1) ? ABL_1P3_PS :
        (LOOP_CTRL.abl_code == 2'h2) ? ABL_6P0_PS : ABL_2P9_PS;
    lock_rise_a: assert property ($rose(LOCK_STATUS_PIN) |-> $past(CMP_SAMPLE.valid))
        else $error("lock rose without a sample");
    lock_fall_a: assert property ($fell(LOCK_STATUS_PIN) |->
        $past(CMP_SAMPLE.valid && CMP_SAMPLE.beyond_loss) || $past(REG_REQ.wr, 2))
        else $error("lock fell without cause");
    loss_clear_a: assert property (LOCK_STATUS_PIN && CMP_SAMPLE.valid &&
        CMP_SAMPLE.beyond_loss |=> !LOCK_STATUS_PIN) else $error("lock kept past loss");
    miss_restart_a: assert property (!LOCK_STATUS_PIN && miss |=> !LOCK_STATUS_PIN [*5])
        else $error("lock too soon after miss");
    align_idle_a: assert property (!ALIGN_REQ |=>
        !LOOP_CTRL.cnt_rst_async && !LOOP_CTRL.cnt_rst_sync) else $error("stray counter reset");
    abl_width_a: assert property (!$past(RESET) |-> LOOP_CTRL.abl_width_ps == abl_exp)
        else $error("antibacklash width mismatch");
    delay_reset_a: assert property ($past(RESET) |->
        LOOP_CTRL.ref_delay == 3'h0 && LOOP_CTRL.fb_delay == 3'h0) else $error("delay not zero");
    read_idle_a: assert property (!REG_REQ.rd |=> REG_RDATA == '0)
        else $error("read data outside slot");
    cover property ($rose(LOCK_STATUS_PIN));
    cover property ($fell(LOCK_STATUS_PIN));
    cover property (LOOP_CTRL.cnt_rst_sync);
    cover property (LOOP_CTRL.cnt_rst_async);
endmodule // pll_lock_detect_checker
bind pll_lock_detect pll_lock_detect_checker u_pll_lock_detect_checker (.CORE_CLK, .RESET,
    .REG_REQ, .REG_RDATA, .CMP_SAMPLE, .ALIGN_REQ, .LOOP_CTRL, .LOCK_STATUS_PIN, .IRQ);

// ### verification/pll_lock_detect_tb.sv
// Self-checking testbench of the lock detector
`timescale 1ns/10ps
module pll_lock_detect_tb;
    import lock_detect_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic [DATA_W-1:0] rdata;
    cmp_sample_t smp = '0;
    logic align = 1'b0;
    loop_ctrl_t ctrl;
    logic lock_pin;
    logic irq;
    int fails = 0;
    int n_checks = 0;
    int nt[4] = '{5, 16, 64, 255};
    logic [12:0] wt[4] = '{ABL_2P9_PS, ABL_1P3_PS, ABL_6P0_PS, ABL_2P9_PS};
    cmp_sample_t hit;
    cmp_sample_t miss;
    pll_lock_detect u_pll_lock_detect (.CORE_CLK(clk), .RESET(rst), .REG_REQ(req),
        .REG_RDATA(rdata), .CMP_SAMPLE(smp), .ALIGN_REQ(align), .LOOP_CTRL(ctrl),
        .LOCK_STATUS_PIN(lock_pin), .IRQ(irq));
    initial forever #25 clk = ~clk;
    // ==========
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk) req <= '{{idx, 2'b00}, {24'h0, d}, 1'b1, 1'b0};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        @(posedge clk) req <= '{{idx, 2'b00}, 32'h0, 1'b0, 1'b1};
        @(posedge clk) req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Holds one sample result for n consecutive cycles
    task automatic run(input cmp_sample_t s, input int n);
        repeat (n) @(posedge clk) smp <= s;
        @(posedge clk) smp <= '0;
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_LOCK_CFG, 32'h0);
        rd(IDX_CNT_DELAY, 32'h0);
        rd(IDX_ABL_CFG, 32'h0);
        rd(8'h30, 32'h0);
        chk(ctrl.abl_width_ps, ABL_2P9_PS);
        wr(IDX_IRQ_EN, 8'h03);
        for (int i = 0; i < 4; i++) begin
            hit = i[0] ? 4'hA : 4'hC;
            miss = i[0] ? 4'hC : 4'h8;
            wr(IDX_LOCK_CFG, {1'b0, i[1:0], i[0], 4'h0});
            run(hit, nt[i] - 1);
            run(miss, 1);
            run(hit, nt[i] - 1);
            chk(lock_pin, 1'b0);
            run(hit, 1);
            chk(lock_pin, 1'b1);
            run(miss, 1);
            chk(lock_pin, 1'b1);
            run(4'h9, 1);
            chk(lock_pin, 1'b0);
        end
        rd(IDX_IRQ_STAT, 32'h3);
        chk(irq, 1'b1);
        wr(IDX_IRQ_EN, 8'h00);
        #1 chk(irq, 1'b0);
        wr(IDX_IRQ_CLR, 8'h03);
        wr(IDX_IRQ_EN, 8'h03);
        rd(IDX_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        $display("lock and irq tests done");
        wr(IDX_LOCK_CFG, 8'h00);
        run(4'hC, 5);
        chk(lock_pin, 1'b1);
        wr(IDX_LOCK_CFG, 8'h08);
        run(4'hC, 5);
        chk(lock_pin, 1'b0);
        wr(IDX_LOCK_CFG, 8'h00);
        run(4'hC, 5);
        chk(lock_pin, 1'b1);
        rd(IDX_STATUS, 32'h1);
        $display("disable test done");
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CNT_DELAY, {m[1:0], m[2:0], ~m[2:0]});
            @(posedge clk) align <= 1'b1;
            @(posedge clk) align <= 1'b0;
            #1 chk(ctrl.cnt_rst_async, m == 1);
            chk(ctrl.cnt_rst_sync, m == 2);
            chk({ctrl.ref_delay, ctrl.fb_delay}, {m[2:0], ~m[2:0]});
            rd(IDX_CNT_DELAY, {24'h0, m[1:0], m[2:0], ~m[2:0]});
        end
        for (int c = 0; c < 4; c++) begin
            wr(IDX_ABL_CFG, c[7:0]);
            repeat (2) @(posedge clk);
            #1 chk(ctrl.abl_width_ps, wt[c]);
        end
        $display("align and width tests done");
        summarize();
    end
endmodule // pll_lock_detect_tb
